/* inc/rsc_pkg.sv */
// ----------------------------------------------------------------------------
// shared constants of the reset source and state control block
// ----------------------------------------------------------------------------
package rsc_pkg;

	// operating modes reported by the core
	typedef enum logic [1:0] {MODE_NORMAL, MODE_SLOW, MODE_IDLE, MODE_SLEEP} rsc_mode_t;

	// kind of the last reset that was applied
	typedef enum logic [1:0] {KIND_POR, KIND_LVR, KIND_WDT_RUN, KIND_WDT_SLEEP} rsc_kind_t;

	// ------------------------------------------------------------------------
	// register byte offsets on the apb bus
	// ------------------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS   = 8'h00;
	localparam logic [7:0] ADDR_CTRL     = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLR  = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_EN   = 8'h10;

	// status register fields
	localparam int unsigned STAT_TO_BIT   = 0;
	localparam int unsigned STAT_PD_BIT   = 1;
	localparam int unsigned STAT_HOLD_BIT = 2;
	localparam int unsigned STAT_KIND_LSB = 4;

	// control register fields and reset value
	localparam int unsigned CTRL_INT_BIT  = 0;
	localparam int unsigned CTRL_TMR_BIT  = 1;
	localparam int unsigned CTRL_PORT_BIT = 2;
	localparam int unsigned CTRL_W        = 3;
	localparam logic [2:0]  CTRL_RESET    = 3'h0;

	// event bits shared by irq status, clear and enable
	localparam int unsigned EV_POR       = 0;
	localparam int unsigned EV_LVR       = 1;
	localparam int unsigned EV_WDT_RUN   = 2;
	localparam int unsigned EV_WDT_SLEEP = 3;
	localparam int unsigned NUM_EV       = 4;
	localparam logic [3:0]  IRQ_RESET    = 4'h0;

	// ------------------------------------------------------------------------
	// timing: core is held for the power-on delay after a full reset
	// ------------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned RSTD_NS       = 16_700_000;
	localparam int unsigned RSTD_CYC      = RSTD_NS / CLK_PERIOD_NS;
	localparam int unsigned HOLD_W        = 21;

endpackage : rsc_pkg

/* logic/rsc_sync.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// two-stage synchroniser for asynchronous request levels
// ----------------------------------------------------------------------------
module rsc_sync #(
	parameter int unsigned W = 2
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);

	// first stage is read only by the second stage
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic metaQ;
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				metaQ      <= 1'b0;
				syncOut[i] <= 1'b0;
			end else begin
				metaQ      <= asyncIn[i];
				syncOut[i] <= metaQ;
			end
		end
	end

endmodule : rsc_sync

/* logic/rsc_hold.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// core hold timer: busy for a fixed number of cycles after each start
// ----------------------------------------------------------------------------
module rsc_hold #(
	parameter logic [rsc_pkg::HOLD_W-1:0] HoldCycles = rsc_pkg::HOLD_W'(rsc_pkg::RSTD_CYC)
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic start,
	output logic      busy
);

	logic [rsc_pkg::HOLD_W-1:0] cntQ;

	// comes out of power-up already holding; a new start restarts the wait
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cntQ <= HoldCycles;
			busy <= 1'b1;
		end else if (start) begin
			cntQ <= HoldCycles;
			busy <= 1'b1;
		end else if (cntQ > rsc_pkg::HOLD_W'(1)) begin
			cntQ <= cntQ - rsc_pkg::HOLD_W'(1);
		end else begin
			cntQ <= '0;
			busy <= 1'b0;
		end
	end

endmodule : rsc_hold

/* logic/rsc_top.sv */
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module rsc_top #(
	parameter logic [rsc_pkg::HOLD_W-1:0] HoldCycles = rsc_pkg::HOLD_W'(rsc_pkg::RSTD_CYC)
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        porReq,
	input  wire logic        lowVoltageReset,
	input  wire logic        watchdogTimeout,
	input  wire logic [1:0]  opMode,
	input  wire logic        haltExec,
	input  wire logic        clrWatchdogExec,
	output logic             coreHold,
	output logic             pcClear,
	output logic             spLoadTop,
	output logic             spClearZero,
	output logic             periphInit,
	output logic      [1:0]  resetKind,
	output logic             wdtClear,
	output logic             tbClear,
	output logic             intEnable,
	output logic             timerEnable,
	output logic             portOutEnable,
	output logic             timeoutFlag,
	output logic             powerdownFlag,
	output logic             irq
);

	// ------------------------------------------------------------------------
	// request capture
	// ------------------------------------------------------------------------
	logic [1:0] reqSync;
	logic [1:0] reqSyncDlyQ;
	logic       porRise;
	logic       lvrRise;
	logic       porEv;
	logic       lvrEv;
	logic       wdtRunEv;
	logic       wdtSleepEv;
	logic       fullEv;
	logic       sleepy;
	logic       holdBusy;

	// power-on and low-voltage come from analog detectors, so they are synchronised
	rsc_sync #(
		.W(2)
	) u_sync (
		.clk    (clk),
		.nrst   (nrst),
		.asyncIn({lowVoltageReset, porReq}),
		.syncOut(reqSync)
	);

	// edge detect on the synchronised levels, one event per request
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reqSyncDlyQ <= 2'h0;
		end else begin
			reqSyncDlyQ <= reqSync;
		end
	end

	assign porRise = reqSync[0] & ~reqSyncDlyQ[0];
	assign lvrRise = reqSync[1] & ~reqSyncDlyQ[1];
	assign sleepy  = (opMode == rsc_pkg::MODE_IDLE) || (opMode == rsc_pkg::MODE_SLEEP);

	// one winner per cycle; lower sources are dropped, not queued
	assign porEv      = porRise;
	assign lvrEv      = lvrRise & ~porRise;
	assign wdtRunEv   = watchdogTimeout & ~porRise & ~lvrRise & ~sleepy;
	assign wdtSleepEv = watchdogTimeout & ~porRise & ~lvrRise & sleepy;
	// normal-mode watchdog reset takes the same full path as low voltage
	assign fullEv     = porEv | lvrEv | wdtRunEv;

	// ------------------------------------------------------------------------
	// hold timer and sequencer
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_WAKE} rsc_state_t;
	rsc_state_t stQ;

	rsc_hold #(
		.HoldCycles(HoldCycles)
	) u_hold (
		.clk  (clk),
		.nrst (nrst),
		.start(fullEv),
		.busy (holdBusy)
	);

	// the core stays held while the power-on delay runs out
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stQ      <= ST_HOLD;
			coreHold <= 1'b1;
		end else begin
			case (stQ)
				ST_HOLD: begin
					coreHold <= 1'b1;
					if (!holdBusy && !fullEv) begin
						stQ      <= ST_RUN;
						coreHold <= 1'b0;
					end
				end
				ST_RUN: begin
					coreHold <= 1'b0;
					if (fullEv) begin
						stQ      <= ST_HOLD;
						coreHold <= 1'b1;
					end else if (wdtSleepEv) begin
						stQ <= ST_WAKE;
					end
				end
				ST_WAKE: begin
					// partial reset: one cycle to restart from vector zero, no hold
					coreHold <= fullEv;
					stQ      <= fullEv ? ST_HOLD : ST_RUN;
				end
				default: begin
					stQ      <= ST_HOLD;
					coreHold <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// reset flags
	// ------------------------------------------------------------------------
	// the reset events outrank the core's own halt and clear instructions
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timeoutFlag   <= 1'b0;
			powerdownFlag <= 1'b0;
		end else if (porEv) begin
			timeoutFlag   <= 1'b0;
			powerdownFlag <= 1'b0;
		end else if (lvrEv) begin
			timeoutFlag   <= timeoutFlag; // low voltage leaves both alone
			powerdownFlag <= powerdownFlag;
		end else if (wdtRunEv) begin
			timeoutFlag <= 1'b1;
		end else if (wdtSleepEv) begin
			timeoutFlag   <= 1'b1;
			powerdownFlag <= 1'b1;
		end else if (haltExec) begin
			timeoutFlag   <= 1'b0;
			powerdownFlag <= 1'b1;
		end else if (clrWatchdogExec) begin
			timeoutFlag   <= 1'b0;
			powerdownFlag <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// core and peripheral init strobes
	// ------------------------------------------------------------------------
	// pc goes to zero on every kind; sp target depends on the kind
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pcClear     <= 1'b1;
			spLoadTop   <= 1'b1;
			spClearZero <= 1'b0;
		end else begin
			pcClear     <= fullEv | wdtSleepEv;
			spLoadTop   <= fullEv;
			spClearZero <= wdtSleepEv;
		end
	end

	// peripherals reload their per-kind values only on full resets
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			periphInit <= 1'b1;
			resetKind  <= rsc_pkg::KIND_POR;
			wdtClear   <= 1'b1;
			tbClear    <= 1'b1;
		end else begin
			periphInit <= fullEv;
			wdtClear   <= fullEv; // counter restarts at once after the pulse
			tbClear    <= fullEv;
			if (porEv) begin
				resetKind <= rsc_pkg::KIND_POR;
			end else if (lvrEv) begin
				resetKind <= rsc_pkg::KIND_LVR;
			end else if (wdtRunEv) begin
				resetKind <= rsc_pkg::KIND_WDT_RUN;
			end else if (wdtSleepEv) begin
				resetKind <= rsc_pkg::KIND_WDT_SLEEP;
			end
		end
	end

	// ------------------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------------------
	logic                       apbAccess;
	logic                       apbWrite;
	logic                       addrHit;
	logic [31:0]                rdMux;
	logic [rsc_pkg::NUM_EV-1:0] irqStatQ;
	logic [rsc_pkg::NUM_EV-1:0] irqEnQ;
	logic [rsc_pkg::NUM_EV-1:0] irqSet;
	logic [rsc_pkg::NUM_EV-1:0] irqClr;

	// one wait state: pready rises in the second access cycle
	assign apbAccess = psel & penable & ~pready;
	assign apbWrite  = psel & penable & pready & pwrite;

	always_comb begin
		rdMux   = 32'h0000_0000;
		addrHit = 1'b1;
		case (paddr)
			rsc_pkg::ADDR_STATUS: begin
				rdMux[rsc_pkg::STAT_TO_BIT]   = timeoutFlag;
				rdMux[rsc_pkg::STAT_PD_BIT]   = powerdownFlag;
				rdMux[rsc_pkg::STAT_HOLD_BIT] = coreHold;
				rdMux[rsc_pkg::STAT_KIND_LSB +: 2] = resetKind;
			end
			rsc_pkg::ADDR_CTRL: begin
				rdMux[rsc_pkg::CTRL_INT_BIT]  = intEnable;
				rdMux[rsc_pkg::CTRL_TMR_BIT]  = timerEnable;
				rdMux[rsc_pkg::CTRL_PORT_BIT] = portOutEnable;
			end
			rsc_pkg::ADDR_IRQ_STAT: rdMux[rsc_pkg::NUM_EV-1:0] = irqStatQ;
			rsc_pkg::ADDR_IRQ_CLR:  rdMux = 32'h0000_0000; // write-only, reads zero
			rsc_pkg::ADDR_IRQ_EN:   rdMux[rsc_pkg::NUM_EV-1:0] = irqEnQ;
			default:                addrHit = 1'b0;
		endcase
	end

	// read data and error are captured with pready so they stand together
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= apbAccess;
			pslverr <= apbAccess & ~addrHit;
			prdata  <= (apbAccess & ~pwrite) ? rdMux : 32'h0000_0000;
		end
	end

	// software enables; every full reset forces them off again
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			intEnable     <= rsc_pkg::CTRL_RESET[rsc_pkg::CTRL_INT_BIT];
			timerEnable   <= rsc_pkg::CTRL_RESET[rsc_pkg::CTRL_TMR_BIT];
			portOutEnable <= rsc_pkg::CTRL_RESET[rsc_pkg::CTRL_PORT_BIT];
		end else if (fullEv) begin
			intEnable     <= 1'b0;
			timerEnable   <= 1'b0;
			portOutEnable <= 1'b0; // pins fall back to inputs
		end else if (apbWrite && paddr == rsc_pkg::ADDR_CTRL) begin
			intEnable     <= pwdata[rsc_pkg::CTRL_INT_BIT];
			timerEnable   <= pwdata[rsc_pkg::CTRL_TMR_BIT];
			portOutEnable <= pwdata[rsc_pkg::CTRL_PORT_BIT];
		end
	end

	// ------------------------------------------------------------------------
	// interrupt status, clear and enable
	// ------------------------------------------------------------------------
	assign irqSet = {wdtSleepEv, wdtRunEv, lvrEv, porEv};
	assign irqClr = (apbWrite && paddr == rsc_pkg::ADDR_IRQ_CLR) ?
		pwdata[rsc_pkg::NUM_EV-1:0] : '0;

	// status survives full resets so software can see why it restarted
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqStatQ <= rsc_pkg::IRQ_RESET;
		end else begin
			irqStatQ <= (irqStatQ & ~irqClr) | irqSet; // set wins over clear
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqEnQ <= rsc_pkg::IRQ_RESET;
		end else if (apbWrite && paddr == rsc_pkg::ADDR_IRQ_EN) begin
			irqEnQ <= pwdata[rsc_pkg::NUM_EV-1:0];
		end
	end

	// level output, one cycle behind the status
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStatQ & irqEnQ);
		end
	end

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_por_flags;
		porEv |=> !timeoutFlag && !powerdownFlag;
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("power-on left a flag set");

	property p_lvr_flags;
		lvrEv |=> $stable(timeoutFlag) && $stable(powerdownFlag);
	endproperty
	a_lvr_flags: assert property (p_lvr_flags) else $error("low voltage changed a flag");

	property p_wdt_run;
		wdtRunEv |=> timeoutFlag && $stable(powerdownFlag) && periphInit && coreHold;
	endproperty
	a_wdt_run: assert property (p_wdt_run) else $error("normal watchdog reset wrong");

	property p_wdt_sleep;
		wdtSleepEv |=> timeoutFlag && powerdownFlag && spClearZero && pcClear && !periphInit;
	endproperty
	a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep watchdog reset wrong");

	property p_int_off;
		fullEv |=> !intEnable ##1 (coreHold || $past(apbWrite));
	endproperty
	a_int_off: assert property (p_int_off) else $error("interrupts not disabled");

	property p_wdt_clear;
		porEv |=> wdtClear && tbClear ##1 !wdtClear;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear pulse wrong");

	property p_tmr_off;
		porEv |=> !timerEnable;
	endproperty
	a_tmr_off: assert property (p_tmr_off) else $error("timers still on");

	property p_port_in;
		porEv |=> !portOutEnable;
	endproperty
	a_port_in: assert property (p_port_in) else $error("ports not inputs");

	property p_pc_sp;
		porEv |=> pcClear && spLoadTop && !spClearZero;
	endproperty
	a_pc_sp: assert property (p_pc_sp) else $error("pc or sp not reset");

	property p_kind;
		periphInit |-> resetKind != rsc_pkg::KIND_WDT_SLEEP;
	endproperty
	a_kind: assert property (p_kind) else $error("partial reset reloaded peripherals");

	property p_prio;
		porRise && (lvrRise || watchdogTimeout) |=> resetKind == rsc_pkg::KIND_POR;
	endproperty
	a_prio: assert property (p_prio) else $error("power-on lost priority");

	property p_apb_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");

	c_por:   cover property (porEv ##1 coreHold);
	c_lvr:   cover property (lvrEv ##1 resetKind == rsc_pkg::KIND_LVR);
	c_sleep: cover property (wdtSleepEv ##1 spClearZero ##1 stQ == ST_RUN);
	c_irq:   cover property (irqStatQ != '0 ##1 irq);

endmodule : rsc_top

/* verif/rsc_far_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// far side: power-on cell, voltage detector, watchdog and core
// ----------------------------------------------------------------------------
module rsc_far_model (
	input  wire logic       clk,
	output logic            porReq,
	output logic            lowVoltageReset,
	output logic            watchdogTimeout,
	output logic      [1:0] opMode,
	output logic            haltExec,
	output logic            clrWatchdogExec
);
	// every request line idle at time zero, core running in normal mode
	initial begin
		porReq = 1'b0;
		lowVoltageReset = 1'b0;
		watchdogTimeout = 1'b0;
		opMode = 2'h0;
		haltExec = 1'b0;
		clrWatchdogExec = 1'b0;
	end

	// one watchdog overflow while the core sits in mode m
	task automatic fireWdt(input logic [1:0] m);
		@(posedge clk);
		opMode <= m;
		watchdogTimeout <= 1'b1;
		@(posedge clk);
		watchdogTimeout <= 1'b0;
	endtask : fireWdt

	// supply request held a few cycles; the optional watchdog pulse is placed
	// so that it lands on the same edge as the synchronised supply request
	task automatic fireSupply(input logic por, input logic low_voltage_reset, input logic wdt);
		@(posedge clk);
		porReq <= por;
		lowVoltageReset <= low_voltage_reset;
		repeat (2) @(posedge clk);
		watchdogTimeout <= wdt;
		@(posedge clk);
		watchdogTimeout <= 1'b0;
		repeat (3) @(posedge clk);
		porReq <= 1'b0;
		lowVoltageReset <= 1'b0;
	endtask : fireSupply

	// core instruction pulse: halt enters power-down, otherwise clear-watchdog
	task automatic coreOp(input logic halt);
		@(posedge clk);
		haltExec <= halt;
		clrWatchdogExec <= !halt;
		@(posedge clk);
		haltExec <= 1'b0;
		clrWatchdogExec <= 1'b0;
	endtask : coreOp
endmodule : rsc_far_model

/* verif/rsc_top_tb.sv */
`timescale 1ns/1ps
module rsc_top_tb;
	localparam logic [20:0] HOLD = 21'h000008;  // short hold keeps the run brief
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        porReq, lowVoltageReset, watchdogTimeout, haltExec, clrWatchdogExec;
	logic [1:0]  opMode, resetKind;
	logic        coreHold, pcClear, spLoadTop, spClearZero, periphInit, wdtClear, tbClear;
	logic        intEnable, timerEnable, portOutEnable, timeoutFlag, powerdownFlag, irq;
	int          numErrors, checkCount, cycles;

	rsc_top #(.HoldCycles(HOLD)) i_dut (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .porReq(porReq), .lowVoltageReset(lowVoltageReset),
		.watchdogTimeout(watchdogTimeout), .opMode(opMode), .haltExec(haltExec),
		.clrWatchdogExec(clrWatchdogExec), .coreHold(coreHold), .pcClear(pcClear),
		.spLoadTop(spLoadTop), .spClearZero(spClearZero), .periphInit(periphInit),
		.resetKind(resetKind), .wdtClear(wdtClear), .tbClear(tbClear),
		.intEnable(intEnable), .timerEnable(timerEnable), .portOutEnable(portOutEnable),
		.timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag), .irq(irq));

	rsc_far_model i_far (.clk(clk), .porReq(porReq), .lowVoltageReset(lowVoltageReset),
		.watchdogTimeout(watchdogTimeout), .opMode(opMode), .haltExec(haltExec),
		.clrWatchdogExec(clrWatchdogExec));

	// ------------------------------------------------------------------------
	// clock, hang guard and verdict
	// ------------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			numErrors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (numErrors == 0 && checkCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic chkBit(input string what, input logic exp, input logic got);
		checkCount++;
		if (got !== exp) begin
			numErrors++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask : chkBit

	task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
		checkCount++;
		if (got !== exp) begin
			numErrors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chkWord

	// ------------------------------------------------------------------------
	// apb master: request held until pready is sampled, then the wait is checked to be two cycles
	// ------------------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1); // only the bench timeout ends a hung wait
		rd = prdata;
		err = pslverr;
		chkWord("apbWait", 32'h2, 32'(n)); // one wait state: answer in the 2nd access cycle
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// ------------------------------------------------------------------------
	// one reset event: check the cycle of the pcClear pulse, then the tail
	// ------------------------------------------------------------------------
	task automatic evt(input logic [2:0] src, input logic [1:0] m, input logic [1:0] kind,
		input logic to, input logic pd, input logic [2:0] en);
		logic full;
		int   n;
		int   extra;
		int   hold;
		full = (kind != 2'h3);
		fork
			if (src == 3'b001) i_far.fireWdt(m);
			else i_far.fireSupply(src[2], src[1], src[0]);
			begin
				n = 0;
				while (pcClear !== 1'b1 && n < 12) begin
					@(posedge clk);
					#1;
					n++;
				end
				chkBit("pcClear", 1'b1, pcClear);
				chkWord("resetKind", {30'h0, kind}, {30'h0, resetKind});
				chkBit("timeoutFlag", to, timeoutFlag);
				chkBit("powerdownFlag", pd, powerdownFlag);
				chkBit("coreHold", full, coreHold);
				chkBit("spLoadTop", full, spLoadTop);
				chkBit("spClearZero", !full, spClearZero);
				if (full) begin
					chkBit("periphInit", 1'b1, periphInit);
					chkBit("wdtClear", 1'b1, wdtClear);
					chkBit("tbClear", 1'b1, tbClear);
				end
				chkWord("enables", {29'h0, en},
					{29'h0, intEnable, timerEnable, portOutEnable});
				// tail counted from the event edge, not from when the far side
				// returns: a supply request is still held for a few cycles then
				n = 0;
				extra = 0;
				hold = 0;
				while ((coreHold === 1'b1 || n < 6) && n < 40) begin
					@(posedge clk);
					#1;
					n++;
					extra += (pcClear !== 1'b0);
					hold += (coreHold !== 1'b0);
				end
				chkWord("extraPulses", 32'h0, 32'(extra));
				chkBit("holdLen", 1'b1,
					full ? (hold == HOLD) : (hold == 0));
			end
		join
	endtask : evt

	// ------------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------------
	task automatic tReset();
		repeat (12) @(posedge clk);
		#1;
		chkWord("enables", 32'h0, {29'h0, intEnable, timerEnable, portOutEnable});
		chkBit("timeoutFlag", 1'b0, timeoutFlag);
		chkBit("powerdownFlag", 1'b0, powerdownFlag);
		chkWord("resetKind", 32'h0, {30'h0, resetKind});
		apb(1'b0, rsc_pkg::ADDR_CTRL, 32'h0);
		chkWord("ctrlReset", 32'h0, rd);
		apb(1'b0, rsc_pkg::ADDR_IRQ_EN, 32'h0);
		chkWord("irqEnReset", 32'h0, rd);
	endtask : tReset

	// watchdog in each mode with flags cleared first, so set and kept differ
	task automatic tWatchdog();
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, rsc_pkg::ADDR_CTRL, 32'h7);
			i_far.coreOp(1'b0);
			evt(3'b001, 2'(m), (m < 2) ? 2'h2 : 2'h3, 1'b1, m >= 2,
				(m < 2) ? 3'h0 : 3'h7);
		end
	endtask : tWatchdog

	// supply resets, alone and racing other sources
	task automatic tSupply();
		i_far.coreOp(1'b1);
		apb(1'b1, rsc_pkg::ADDR_CTRL, 32'h7);
		evt(3'b010, 2'h0, 2'h1, 1'b0, 1'b1, 3'h0);
		evt(3'b011, 2'h0, 2'h1, 1'b0, 1'b1, 3'h0);
		evt(3'b110, 2'h0, 2'h0, 1'b0, 1'b0, 3'h0);
	endtask : tSupply

	// interrupt status, mask, clear and bus refusals
	task automatic tIrq();
		apb(1'b1, rsc_pkg::ADDR_IRQ_CLR, 32'hF);
		apb(1'b1, rsc_pkg::ADDR_IRQ_EN, 32'h8);
		evt(3'b001, 2'h0, 2'h2, 1'b1, 1'b0, 3'h0);
		chkBit("irqMasked", 1'b0, irq);
		evt(3'b001, 2'h3, 2'h3, 1'b1, 1'b1, 3'h0);
		chkBit("irqSet", 1'b1, irq);
		apb(1'b0, rsc_pkg::ADDR_IRQ_STAT, 32'h0);
		chkWord("irqStat", 32'hC, rd);
		apb(1'b1, rsc_pkg::ADDR_IRQ_CLR, 32'h8);
		apb(1'b1, rsc_pkg::ADDR_IRQ_STAT, 32'h0);
		chkBit("irqCleared", 1'b0, irq);
		apb(1'b0, rsc_pkg::ADDR_IRQ_STAT, 32'h0);
		chkWord("irqStatRo", 32'h4, rd);
		apb(1'b1, rsc_pkg::ADDR_IRQ_EN, 32'h4);
		apb(1'b0, rsc_pkg::ADDR_IRQ_CLR, 32'h0);
		chkWord("irqClrRead", 32'h0, rd);
		chkBit("irqUnmasked", 1'b1, irq);
		apb(1'b1, rsc_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, rsc_pkg::ADDR_STATUS, 32'h0);
		chkWord("status", 32'h33, rd);
		apb(1'b1, 8'h14, 32'hFFFF_FFFF);
		chkBit("slvErrWr", 1'b1, err);
		apb(1'b0, 8'h14, 32'h0);
		chkBit("slvErrRd", 1'b1, err);
		chkWord("unmappedRead", 32'h0, rd);
	endtask : tIrq

	// ------------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		tReset();
		tWatchdog();
		tSupply();
		tIrq();
		wrap_up();
	end
endmodule : rsc_top_tb
